// *** core/mpn_consts.svh ***
// Constants of the measurement post-processing block.
`ifndef MPN_CONSTS_SVH
`define MPN_CONSTS_SVH

`define MPN_ADDR_W 8
`define MPN_OFS_CTRL 8'h00
`define MPN_OFS_INTEG 8'h04
`define MPN_OFS_ARDLY 8'h08
`define MPN_OFS_UPPER 8'h0C
`define MPN_OFS_LOWER 8'h10
`define MPN_OFS_MTIME 8'h14
`define MPN_OFS_AREFF 8'h18
`define MPN_OFS_NULLREF 8'h1C
`define MPN_OFS_RESULT 8'h20
`define MPN_OFS_HEADER 8'h24
`define MPN_OFS_EVT_STAT 8'h28
`define MPN_OFS_EVT_EN 8'h2C
`define MPN_OFS_EVT_CLR 8'h30

`define MPN_CTRL_SRC_LSB 0
`define MPN_CTRL_STORE_LSB 2
`define MPN_CTRL_NULL 4
`define MPN_CTRL_CMP 5
`define MPN_CTRL_DISP_OFF 6
`define MPN_CTRL_FUNC_CUR 7
`define MPN_CTRL_AUTO 8
`define MPN_CTRL_SEL_LSB 9
`define MPN_CTRL_INIT 31

`define MPN_SRC_DC 2'h0
`define MPN_STORE_OFF 2'h0
`define MPN_STORE_NORMAL 2'h1
`define MPN_STORE_BURST 2'h2

`define MPN_OUT_NONE 2'h0
`define MPN_OUT_HI 2'h1
`define MPN_OUT_GO 2'h2
`define MPN_OUT_LO 2'h3

`define MPN_EVT_HI 0
`define MPN_EVT_GO 1
`define MPN_EVT_LO 2

`define MPN_INTEG_MIN_US 32'h0000_01F4
`define MPN_INTEG_MAX_US 32'h001E_8480
`define MPN_INTEG_RESET_US 32'h0000_4E20

`define MPN_TK_DC_OFF_US 32'h0000_157C
`define MPN_TK_DC_NORM_US 32'h0000_16A8
`define MPN_TK_DC_BURST_US 32'h0000_0C80
`define MPN_TK_OT_OFF_US 32'h0000_1194
`define MPN_TK_OT_NORM_US 32'h0000_125C
`define MPN_TK_OT_BURST_US 32'h0000_0898
`define MPN_TK_NULL_US 32'h0000_00FA
`define MPN_TK_CMP_US 32'h0000_0258
`define MPN_TK_DISP_US 32'h0000_00FA

`define MPN_RANGE_TOP 3'h5
`define MPN_RANGE_NODELAY 3'h4
`define MPN_FS_BASE 32'h0000_7D00
`define MPN_FS_TOP 32'h7735_9400
`define MPN_LIM_MAX_I 32'h7735_9400
`define MPN_LIM_MAX_V 32'h0001_ADB0

`define MPN_PULSE_NS 25000
`define MPN_CLK_NS 25
`define MPN_PULSE_CYC ((`MPN_PULSE_NS + `MPN_CLK_NS - 1) / `MPN_CLK_NS)

`endif

// *** core/mpn_pkg.sv ***
// Types of the measurement post-processing block.
package mpn_pkg;

    typedef struct packed {
        logic valid;
        logic ovr;
        logic [2:0] range;
        logic [31:0] value;
    } mpn_meas_s;

    typedef struct packed {
        logic valid;
        logic ovr;
        logic [2:0] range;
        logic [31:0] value;
        logic [1:0] outcome;
    } mpn_result_s;

    typedef struct packed {
        logic [1:0] src;
        logic [1:0] store;
        logic null_en;
        logic cmp_en;
        logic disp_off;
        logic func_cur;
        logic auto_rng;
        logic [1:0] pulse_sel;
    } mpn_ctrl_s;

    typedef struct packed {
        mpn_ctrl_s ctrl;
        logic [31:0] integ;
        logic [31:0] ar_ta;
        logic [31:0] upper;
        logic [31:0] lower;
        logic [31:0] null_ref;
        logic null_ovr;
        logic [2:0] null_range;
        logic cap_pend;
        logic [31:0] res;
        logic res_ovr;
        logic [2:0] res_range;
        logic res_valid;
        logic [1:0] outcome;
        logic [2:0] evt_stat;
        logic [2:0] evt_en;
        logic irq;
        logic [15:0] pulse_cnt;
        logic complete_n;
        logic done;
        logic [2:0] range_floor;
        logic [31:0] tm;
        logic [31:0] ar_eff;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mpn_state_s;

endpackage

// *** core/mpn_postproc.sv ***
// Measurement post-processing: timing, null subtraction and limit compare.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`include "mpn_consts.svh"

// Function
// - Measure time is integration plus overhead.
// - Integration time clamped 500 us to 2000 ms.
// - Overhead chosen by source and storage mode.
// - Null, compare, display adjust non-burst overhead.
// - Range delay only for current autoranging.
// - Range delay divided by ten per decade, zero from range 4.
// - Null result is value minus reference.
// - First measurement after null on is captured.
// - Reference reloads on null enable or init.
// - Over-range reference makes results over-range.
// - Current null result beyond full scale moves range up.
// - Changing measurement function turns null off.
// - Autorange floor is the capture range.
// - Above upper HI, below lower LO, else GO.
// - Over-range sign decides HI or LO.
// - Compare uses null-corrected result and its sign.
// - Outcome to header, event register, low pulse.
// - Signed limits default zero, magnitude clamped.
module mpn_postproc
    import mpn_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MPN_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Raw measurement from the converter logic.
    input wire mpn_meas_s meas,
    // Processed result and control to the ranging logic.
    output mpn_result_s result,
    output logic [2:0] range_floor,
    output logic [31:0] measure_total_time,
    output logic [31:0] autorange_settle_delay,
    // Completion pulse and interrupt.
    output logic complete_n,
    output logic irq
);

    mpn_state_s st;
    mpn_state_s next_st;

    function automatic logic [31:0] full_scale(input logic [2:0] rng);
        logic [31:0] fs;
        fs = `MPN_FS_BASE;
        for (int i = 0; i < 5; i++) begin
            if (i < int'(rng)) begin
                fs = fs * 32'h0000_000A;
            end
        end
        if (rng >= `MPN_RANGE_TOP) begin
            fs = `MPN_FS_TOP;
        end
        return fs;
    endfunction

    function automatic logic [31:0] magnitude(input logic [31:0] v);
        return v[31] ? (32'h0 - v) : v;
    endfunction

    function automatic logic [31:0] clamp_limit(input logic [31:0] v,
                                                input logic cur);
        logic [31:0] lim;
        lim = cur ? `MPN_LIM_MAX_I : `MPN_LIM_MAX_V;
        if (magnitude(v) <= lim) begin
            return v;
        end
        return v[31] ? (32'h0 - lim) : lim;
    endfunction

    function automatic logic [31:0] overhead(input mpn_ctrl_s c);
        logic [31:0] tk;
        tk = 32'h0;
        if (c.src == `MPN_SRC_DC) begin
            unique case (c.store)
                `MPN_STORE_NORMAL: tk = `MPN_TK_DC_NORM_US;
                `MPN_STORE_BURST: tk = `MPN_TK_DC_BURST_US;
                default: tk = `MPN_TK_DC_OFF_US;
            endcase
        end else begin
            unique case (c.store)
                `MPN_STORE_NORMAL: tk = `MPN_TK_OT_NORM_US;
                `MPN_STORE_BURST: tk = `MPN_TK_OT_BURST_US;
                default: tk = `MPN_TK_OT_OFF_US;
            endcase
        end
        if (c.store != `MPN_STORE_BURST) begin
            if (c.null_en) begin
                tk = tk + `MPN_TK_NULL_US;
            end
            if (c.cmp_en) begin
                tk = tk + `MPN_TK_CMP_US;
            end
            if (c.disp_off) begin
                tk = tk - `MPN_TK_DISP_US;
            end
        end
        return tk;
    endfunction

    function automatic logic [31:0] range_delay(input logic [31:0] ta,
                                                input logic [2:0] rng);
        unique case (rng)
            3'h0: return ta;
            3'h1: return ta / 32'h0000_000A;
            3'h2: return ta / 32'h0000_0064;
            3'h3: return ta / 32'h0000_03E8;
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [1:0] judge(input logic [31:0] x,
                                         input logic ovr,
                                         input logic [31:0] up,
                                         input logic [31:0] lo);
        if (ovr) begin
            return x[31] ? `MPN_OUT_LO : `MPN_OUT_HI;
        end
        if ($signed(x) > $signed(up)) begin
            return `MPN_OUT_HI;
        end
        if ($signed(x) < $signed(lo)) begin
            return `MPN_OUT_LO;
        end
        return `MPN_OUT_GO;
    endfunction

    // Control register packing, both directions.
    function automatic logic [31:0] ctrl_word(input mpn_ctrl_s c);
        logic [31:0] w;
        w = 32'h0;
        w[`MPN_CTRL_SRC_LSB +: 2] = c.src;
        w[`MPN_CTRL_STORE_LSB +: 2] = c.store;
        w[`MPN_CTRL_NULL] = c.null_en;
        w[`MPN_CTRL_CMP] = c.cmp_en;
        w[`MPN_CTRL_DISP_OFF] = c.disp_off;
        w[`MPN_CTRL_FUNC_CUR] = c.func_cur;
        w[`MPN_CTRL_AUTO] = c.auto_rng;
        w[`MPN_CTRL_SEL_LSB +: 2] = c.pulse_sel;
        return w;
    endfunction

    function automatic mpn_ctrl_s ctrl_fields(input logic [31:0] w);
        mpn_ctrl_s c;
        c.src = w[`MPN_CTRL_SRC_LSB +: 2];
        c.store = w[`MPN_CTRL_STORE_LSB +: 2];
        c.null_en = w[`MPN_CTRL_NULL];
        c.cmp_en = w[`MPN_CTRL_CMP];
        c.disp_off = w[`MPN_CTRL_DISP_OFF];
        c.func_cur = w[`MPN_CTRL_FUNC_CUR];
        c.auto_rng = w[`MPN_CTRL_AUTO];
        c.pulse_sel = w[`MPN_CTRL_SEL_LSB +: 2];
        return c;
    endfunction

    // Register bus decode shared by reads, errors and writes.
    function automatic logic [31:0] read_word(input mpn_state_s s,
                                              input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0;
        unique case (a)
            `MPN_OFS_CTRL: w = ctrl_word(s.ctrl);
            `MPN_OFS_INTEG: w = s.integ;
            `MPN_OFS_ARDLY: w = s.ar_ta;
            `MPN_OFS_UPPER: w = s.upper;
            `MPN_OFS_LOWER: w = s.lower;
            `MPN_OFS_MTIME: w = s.tm;
            `MPN_OFS_AREFF: w = s.ar_eff;
            `MPN_OFS_NULLREF: w = s.null_ref;
            `MPN_OFS_RESULT: w = s.res;
            `MPN_OFS_HEADER: w = {23'h0, s.ctrl.null_en, 1'b0,
                s.res_range, 1'b0, s.res_ovr, s.outcome};
            `MPN_OFS_EVT_STAT: w = {29'h0, s.evt_stat};
            `MPN_OFS_EVT_EN: w = {29'h0, s.evt_en};
            default: w = 32'h0;
        endcase
        return w;
    endfunction

    function automatic logic addr_mapped(input logic [`MPN_ADDR_W-1:0] a);
        logic hit;
        unique case (a)
            `MPN_OFS_CTRL, `MPN_OFS_INTEG, `MPN_OFS_ARDLY, `MPN_OFS_UPPER,
            `MPN_OFS_LOWER, `MPN_OFS_MTIME, `MPN_OFS_AREFF,
            `MPN_OFS_NULLREF, `MPN_OFS_RESULT, `MPN_OFS_HEADER,
            `MPN_OFS_EVT_STAT, `MPN_OFS_EVT_EN,
            `MPN_OFS_EVT_CLR: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    logic access;
    logic wr;
    logic [32:0] diff;
    logic [31:0] corr;
    logic corr_ovr;
    logic [2:0] corr_range;
    logic [31:0] ref_val;
    logic ref_ovr;
    logic [31:0] integ_w;
    logic [2:0] stat_set;

    assign access = psel && penable && st.pready;
    assign wr = access && pwrite;

    always_comb begin
        next_st = st;
        stat_set = 3'h0;
        integ_w = pwdata;
        ref_val = st.null_ref;
        ref_ovr = st.null_ovr;
        diff = 33'h0;
        corr = 32'h0;
        corr_ovr = 1'b0;
        corr_range = meas.range;

        // APB answers in the access phase that follows every setup phase.
        next_st.pready = psel && !penable;
        next_st.pslverr = 1'b0;
        if (psel && !penable) begin
            next_st.prdata = read_word(st, paddr);
            next_st.pslverr = !addr_mapped(paddr);
        end

        if (wr && addr_mapped(paddr)) begin
            unique case (paddr)
                `MPN_OFS_CTRL: begin
                    next_st.ctrl = ctrl_fields(pwdata);
                    if (pwdata[`MPN_CTRL_FUNC_CUR] != st.ctrl.func_cur) begin
                        next_st.ctrl.null_en = 1'b0;
                    end
                    if (next_st.ctrl.null_en && !st.ctrl.null_en) begin
                        next_st.cap_pend = 1'b1;
                    end
                    if (pwdata[`MPN_CTRL_INIT]) begin
                        next_st.cap_pend = next_st.ctrl.null_en;
                    end
                    if (!next_st.ctrl.null_en) begin
                        next_st.cap_pend = 1'b0;
                    end
                end
                `MPN_OFS_INTEG: begin
                    if (integ_w < `MPN_INTEG_MIN_US) begin
                        integ_w = `MPN_INTEG_MIN_US;
                    end
                    if (integ_w > `MPN_INTEG_MAX_US) begin
                        integ_w = `MPN_INTEG_MAX_US;
                    end
                    next_st.integ = integ_w;
                end
                `MPN_OFS_ARDLY: next_st.ar_ta = pwdata;
                `MPN_OFS_UPPER: next_st.upper =
                    clamp_limit(pwdata, st.ctrl.func_cur);
                `MPN_OFS_LOWER: next_st.lower =
                    clamp_limit(pwdata, st.ctrl.func_cur);
                `MPN_OFS_EVT_EN: next_st.evt_en = pwdata[2:0];
                `MPN_OFS_EVT_CLR: next_st.evt_stat = st.evt_stat & ~pwdata[2:0];
                default: ;
            endcase
        end

        next_st.tm = st.integ + overhead(st.ctrl);
        if (st.ctrl.func_cur && st.ctrl.auto_rng) begin
            next_st.ar_eff = range_delay(st.ar_ta, meas.range);
        end else begin
            next_st.ar_eff = 32'h0;
        end
        next_st.range_floor = 3'h0;
        if (st.ctrl.null_en && !st.cap_pend) begin
            next_st.range_floor = st.null_range;
        end

        // First pipeline stage: null capture and subtraction.
        next_st.res_valid = 1'b0;
        if (meas.valid) begin
            if (st.ctrl.null_en && st.cap_pend) begin
                ref_val = meas.value;
                ref_ovr = meas.ovr;
                next_st.null_ref = meas.value;
                next_st.null_ovr = meas.ovr;
                next_st.null_range = meas.range;
                next_st.cap_pend = 1'b0;
            end
            if (st.ctrl.null_en) begin
                diff = {meas.value[31], meas.value} - {ref_val[31], ref_val};
                corr = diff[31:0];
                corr_ovr = meas.ovr || ref_ovr || (diff[32] != diff[31]);
                if (meas.ovr) begin
                    corr = meas.value;
                end
                if (st.ctrl.func_cur && !corr_ovr &&
                    magnitude(corr) > full_scale(meas.range)) begin
                    if (meas.range >= `MPN_RANGE_TOP ||
                        magnitude(corr) > full_scale(meas.range + 3'h1)) begin
                        corr_ovr = 1'b1;
                    end else begin
                        corr_range = meas.range + 3'h1;
                    end
                end
            end else begin
                corr = meas.value;
                corr_ovr = meas.ovr;
            end
            next_st.res = corr;
            next_st.res_ovr = corr_ovr;
            next_st.res_range = corr_range;
            next_st.res_valid = 1'b1;
        end

        // Completion pulse counts down unless a new outcome equal to pulse_sel restarts it.
        if (st.pulse_cnt != 16'h0) begin
            next_st.pulse_cnt = st.pulse_cnt - 16'h1;
        end

        // Second stage: one judgment per finished, corrected value.
        next_st.done = st.res_valid;
        if (st.res_valid) begin
            if (st.ctrl.cmp_en) begin
                next_st.outcome = judge(st.res, st.res_ovr,
                                        st.upper, st.lower);
                unique case (next_st.outcome)
                    `MPN_OUT_HI: stat_set[`MPN_EVT_HI] = 1'b1;
                    `MPN_OUT_GO: stat_set[`MPN_EVT_GO] = 1'b1;
                    `MPN_OUT_LO: stat_set[`MPN_EVT_LO] = 1'b1;
                    default: ;
                endcase
                if (next_st.outcome == st.ctrl.pulse_sel) begin
                    next_st.pulse_cnt = 16'(`MPN_PULSE_CYC);
                end
            end else begin
                next_st.outcome = `MPN_OUT_NONE;
            end
        end
        next_st.evt_stat = next_st.evt_stat | stat_set;
        next_st.complete_n = (next_st.pulse_cnt == 16'h0);
        next_st.irq = |(next_st.evt_stat & next_st.evt_en);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st <= '0;
            st.integ <= `MPN_INTEG_RESET_US;
            st.complete_n <= 1'b1;
            st.tm <= `MPN_INTEG_RESET_US + `MPN_TK_DC_OFF_US;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign result.valid = st.done;
    assign result.ovr = st.res_ovr;
    assign result.range = st.res_range;
    assign result.value = st.res;
    assign result.outcome = st.outcome;
    assign range_floor = st.range_floor;
    assign measure_total_time = st.tm;
    assign autorange_settle_delay = st.ar_eff;
    assign complete_n = st.complete_n;
    assign irq = st.irq;

endmodule // mpn_postproc

// *** bench/mpn_postproc_properties.sv ***
// Checker of the measurement post-processing block.
`timescale 1ns/1ps
`include "mpn_consts.svh"
module mpn_chk
    import mpn_pkg::*;
(
    // Clock, reset and bus handshake.
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    // Measurement path.
    input wire mpn_meas_s meas,
    input wire mpn_result_s result,
    input wire logic [31:0] measure_total_time,
    input wire logic [31:0] autorange_settle_delay,
    input wire logic complete_n,
    input wire logic irq
);
    logic [15:0] low_run;
    logic wr_acc;

    // Counts low cycles of the completion pulse since the last result.
    assign wr_acc = psel && penable && pready && pwrite;
    always_ff @(posedge core_clk) begin
        if (!rst_b || complete_n) begin
            low_run <= 16'h0000;
        end else if (result.valid) begin
            low_run <= 16'h0001;
        end else begin
            low_run <= low_run + 16'h0001;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_taken;
        meas.valid;
    endsequence

    a_ready_answer: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_result_latency: assert property (
        s_taken |-> ##2 result.valid)
        else $error("result not two cycles after sample");
    a_pulse_cause: assert property (
        $fell(complete_n) |-> result.valid)
        else $error("pulse without result");
    a_pulse_min: assert property (
        $fell(complete_n) |=> !complete_n [*8])
        else $error("pulse too short");
    a_pulse_bound: assert property (
        !complete_n |-> low_run < 16'h03E8)
        else $error("pulse too long");
    a_delay_zero: assert property (
        meas.range >= `MPN_RANGE_NODELAY |=> autorange_settle_delay == 32'h0)
        else $error("delay in high range");
    a_time_range: assert property (
        measure_total_time >= 32'hA8C && measure_total_time <= 32'h1E9E7A)
        else $error("total time out of range");
    a_irq_cause: assert property (
        $changed(irq) |-> result.valid || $past(result.valid)
            || $past(wr_acc) || $past(wr_acc, 2))
        else $error("interrupt changed without cause");
endmodule // mpn_chk

bind mpn_postproc mpn_chk u_mpn_chk (
    .core_clk, .rst_b, .psel, .penable, .pwrite, .pready, .meas, .result,
    .measure_total_time, .autorange_settle_delay, .complete_n, .irq
);

// *** bench/tb.sv ***
// Self-checking testbench of the measurement post-processing block.
`timescale 1ns/1ps
`include "mpn_consts.svh"
module tb
    import mpn_pkg::*;
;
    typedef struct {
        logic [31:0] integ;
        logic [31:0] ctrl;
        logic [31:0] mtime;
        logic ovr;
        logic [31:0] value;
        logic [1:0] outc;
    } mpn_row_s;
    mpn_row_s rows [7] = '{
        '{32'h64, 32'h4A0, 32'h19C8, 1'b0, 32'h3E9, 2'h1},
        '{32'h1F4, 32'h4A4, 32'h1AF4, 1'b0, 32'h3E8, 2'h2},
        '{32'h2DC6C0, 32'h4A8, 32'h1E9100, 1'b0, 32'hFFFFFC18, 2'h2},
        '{32'h4E20, 32'h4A1, 32'h620C, 1'b0, 32'hFFFFFC17, 2'h3},
        '{32'h4E20, 32'h4E6, 32'h61DA, 1'b0, 32'h0, 2'h2},
        '{32'h4E20, 32'h4EB, 32'h56B8, 1'b1, 32'h5, 2'h1},
        '{32'h4E20, 32'h4A0, 32'h65F4, 1'b1, 32'hFFFFFFFB, 2'h3}
    };
    logic core_clk = 1'b0;
    logic rst_b, psel, penable, pwrite, pready, pslverr, pe;
    logic complete_n, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, measure_total_time, autorange_settle_delay;
    logic [31:0] rd, e;
    logic [2:0] range_floor;
    mpn_meas_s meas;
    mpn_result_s result, res;
    int bad_count = 0;
    int n_tests = 0;
    int n;

    mpn_postproc u_mpn_postproc (
        .core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .meas, .result, .range_floor,
        .measure_total_time, .autorange_settle_delay, .complete_n, .irq
    );

    always #12.5 core_clk = ~core_clk;

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %0h", $time, m, got);
        end
    endtask

    task automatic hang(input string m);
        bad_count++;
        $display("unexpected at %0t: %s timed out", $time, m);
        close_out();
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        k = 0;
        do begin
            tick(1);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) hang("bus");
        rd = prdata;
        pe = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask

    task automatic mv(input logic o, input logic [2:0] r,
        input logic [31:0] v);
        int k;
        meas <= '{1'b1, o, r, v};
        tick(1);
        meas.valid <= 1'b0;
        k = 0;
        do begin
            tick(1);
            k++;
        end while (result.valid !== 1'b1 && k < 8);
        if (result.valid !== 1'b1) hang("result");
        res = result;
    endtask

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        meas = '0;
        tick(16);
        rst_b <= 1'b1;
        tick(1);
        chk(measure_total_time, 32'h639C, "reset time");
        chk(32'(complete_n), 32'h1, "reset pulse");
        apb(1'b0, `MPN_OFS_UPPER, 32'h0);
        chk(rd, 32'h0, "upper default");
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(pe), 32'h1, "unmapped");
        $display("test reset finished");
        apb(1'b1, `MPN_OFS_CTRL, 32'h4A0);
        apb(1'b1, `MPN_OFS_UPPER, 32'h3E8);
        apb(1'b1, `MPN_OFS_LOWER, 32'hFFFFFC18);
        foreach (rows[i]) begin
            apb(1'b1, `MPN_OFS_CTRL, rows[i].ctrl);
            apb(1'b1, `MPN_OFS_INTEG, rows[i].integ);
            tick(3);
            chk(measure_total_time, rows[i].mtime, "time");
            mv(rows[i].ovr, 3'h2, rows[i].value);
            chk(32'(res.outcome), 32'(rows[i].outc), "outcome");
        end
        apb(1'b0, `MPN_OFS_EVT_STAT, 32'h0);
        chk(rd, 32'h7, "events");
        chk(32'(irq), 32'h0, "irq masked");
        apb(1'b1, `MPN_OFS_EVT_EN, 32'h1);
        tick(2);
        chk(32'(irq), 32'h1, "irq raised");
        apb(1'b1, `MPN_OFS_EVT_CLR, 32'h1);
        tick(2);
        chk(32'(irq), 32'h0, "irq cleared");
        apb(1'b0, `MPN_OFS_EVT_STAT, 32'h0);
        chk(rd, 32'h6, "events cleared");
        n = 0;
        while (complete_n !== 1'b1 && n < 1100) begin
            tick(1);
            n++;
        end
        if (complete_n !== 1'b1) hang("idle");
        mv(1'b0, 3'h2, 32'h0);
        n = 0;
        while (complete_n === 1'b0 && n < 1100) begin
            n++;
            tick(1);
        end
        chk(32'(n), 32'h3E8, "pulse width");
        $display("test compare finished");
        apb(1'b1, `MPN_OFS_CTRL, 32'h4B0);
        tick(3);
        chk(measure_total_time, 32'h66EE, "null time");
        mv(1'b0, 3'h2, 32'h1F4);
        chk(res.value, 32'h0, "capture");
        apb(1'b0, `MPN_OFS_NULLREF, 32'h0);
        chk(rd, 32'h1F4, "reference");
        mv(1'b0, 3'h2, 32'h514);
        chk(res.value, 32'h320, "subtract");
        chk(32'(res.outcome), 32'h2, "null compare");
        apb(1'b0, `MPN_OFS_HEADER, 32'h0);
        chk(rd, 32'h122, "header");
        apb(1'b1, `MPN_OFS_CTRL, 32'h4B0);
        mv(1'b0, 3'h2, 32'h384);
        chk(res.value, 32'h190, "no reload");
        chk(32'(range_floor), 32'h2, "floor");
        apb(1'b1, `MPN_OFS_CTRL, 32'h800004B0);
        mv(1'b0, 3'h0, 32'hC8);
        mv(1'b0, 3'h0, 32'h9C40);
        chk(res.value, 32'h9B78, "init reload");
        chk(32'(res.range), 32'h1, "range up");
        apb(1'b1, `MPN_OFS_CTRL, 32'h4A0);
        apb(1'b1, `MPN_OFS_CTRL, 32'h4B0);
        mv(1'b1, 3'h2, 32'h5);
        mv(1'b0, 3'h2, 32'h64);
        chk(32'(res.ovr), 32'h1, "ovr reference");
        apb(1'b1, `MPN_OFS_CTRL, 32'h30);
        apb(1'b0, `MPN_OFS_CTRL, 32'h0);
        chk(32'(rd[4]), 32'h0, "function change");
        $display("test null finished");
        apb(1'b1, `MPN_OFS_ARDLY, 32'h7A120);
        apb(1'b1, `MPN_OFS_CTRL, 32'h180);
        e = 32'h7A120;
        for (int r = 0; r < 6; r++) begin
            meas.range <= 3'(r);
            tick(3);
            chk(autorange_settle_delay, r < 4 ? e : 32'h0, "delay");
            e = e / 32'hA;
        end
        apb(1'b1, `MPN_OFS_CTRL, 32'h80);
        meas.range <= 3'h0;
        tick(3);
        chk(autorange_settle_delay, 32'h0, "fixed range");
        apb(1'b1, `MPN_OFS_CTRL, 32'h100);
        tick(3);
        chk(autorange_settle_delay, 32'h0, "voltage range");
        $display("test autorange finished");
        apb(1'b1, `MPN_OFS_INTEG, 32'h1F4);
        apb(1'b1, `MPN_OFS_EVT_EN, 32'h7);
        tick(3);
        chk(32'(irq), 32'h1, "irq before reset");
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        tick(2);
        chk(measure_total_time, 32'h639C, "reset time again");
        chk(32'(irq), 32'h0, "reset irq");
        chk(32'(range_floor), 32'h0, "reset floor");
        chk(32'(complete_n), 32'h1, "reset pulse again");
        apb(1'b0, `MPN_OFS_INTEG, 32'h0);
        chk(rd, 32'h4E20, "reset integration");
        $display("test mid reset finished");
        close_out();
    end
endmodule // tb
